// *** dv/iogb_pad_model.sv ***
// Far-side pad model: pattern source on the pad, capture of serial lanes.
`timescale 1ns/1ps
module iogb_pad_model (
	input logic		pclk,
	input logic		serial_out_a,
	input logic		serial_out_c,
	output logic		pad_in,
	output logic [15:0]	pad_hist,
	output logic [31:0]	cap_a,
	output logic [31:0]	cap_c
);
	logic [15:0]	lfsr = 16'hace1;
	assign pad_in = lfsr[0];
	// The pad moves on both edges so a falling capture differs from a rising one.
	always @(posedge pclk or negedge pclk) begin
		lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		pad_hist <= {pad_hist[14:0], pad_in};
	end
	// Lanes shift in from the top, so the first bit sent ends up lowest.
	always @(posedge pclk) begin
		cap_a <= {serial_out_a, cap_a[31:1]};
		cap_c <= {serial_out_c, cap_c[31:1]};
	end
endmodule

// *** dv/iogb_props.sv ***
// Port-level assertions for the I/O gearbox top.
`timescale 1ns/1ps
module iogb_props (
	input logic		pclk,
	input logic		presetn,
	input logic		psel,
	input logic		penable,
	input logic		pwrite,
	input logic [11:0]	paddr,
	input logic [31:0]	pwdata,
	input logic [31:0]	prdata,
	input logic		pready,
	input logic		pslverr,
	input logic		pad_in,
	input logic		bypass_comb_input,
	input logic		bypass_clock_output,
	input logic		core_valid,
	input logic		core_ready,
	input logic		serial_out_a,
	input logic		serial_out_c
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence apb_access;
		psel && penable;
	endsequence
	sequence gb_rst_write;
		apb_access ##0 (pwrite && paddr == 12'h000 && pwdata[0]);
	endsequence
	chk_bypass_copy: assert property (
		bypass_clock_output == bypass_comb_input)
		else $error("bypass copies differ");
	chk_bypass_gate: assert property (
		bypass_comb_input |-> pad_in)
		else $error("bypass output high with pad low");
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_unmapped_err: assert property (
		apb_access ##0 (paddr > 12'h008) |-> pslverr)
		else $error("unmapped access without error");
	chk_status_ro: assert property (
		apb_access ##0 (pwrite && paddr == 12'h008) |-> pslverr)
		else $error("status write without error");
	chk_read_upper: assert property (
		apb_access ##0 !pwrite |-> prdata[31:7] == 25'h0)
		else $error("unused read bits set");
	chk_buf_fall: assert property ($fell(core_ready) |-> $past(core_valid))
		else $error("ready fell with no word offered");
	chk_gb_rst_low: assert property (
		gb_rst_write |-> ##2 (!serial_out_a && !serial_out_c))
		else $error("serial output not cleared by gearbox reset");
	chk_start_low: assert property (
		$rose(presetn) |-> (!serial_out_a && !serial_out_c)[*3])
		else $error("serial output active right after reset");
endmodule

bind iogb_top iogb_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in, .bypass_comb_input,
	.bypass_clock_output, .core_valid, .core_ready, .serial_out_a,
	.serial_out_c);

// *** dv/iogb_top_tb.sv ***
// Self-checking bench for the I/O gearbox top level.
`timescale 1ns/1ps
`include "iogb_regs.svh"
module iogb_top_tb;
	logic		pclk = 1'b0;
	logic		presetn = 1'b0;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0;
	logic		core_valid = 1'b0;
	logic [7:0]	core_word = 8'h00;
	logic [31:0]	prdata;
	logic		pready;
	logic		pslverr;
	logic		pad_in;
	logic		bypass_comb_input;
	logic		bypass_clock_output;
	logic		rising_sample_out;
	logic		falling_or_sdr_sample_out;
	logic		core_ready;
	logic		serial_out_a;
	logic		serial_out_c;
	logic [15:0]	pad_hist;
	logic [31:0]	cap_a;
	logic [31:0]	cap_c;
	logic [31:0]	rd;
	logic [31:0]	ex;
	logic		err;
	logic		was_full = 1'b0;
	int		num_errors = 0;
	int		compares = 0;
	int		cyc = 0;
	int		c0 = 0;
	logic [31:0]	cfg [5] = '{32'h00, 32'h08, 32'h20, 32'h40, 32'h10};
	int		r_idx [5] = '{0, 0, 2 * `IOGB_FIXED_TAP + 2, 8, 0};
	int		s_idx [5] = '{0, 1, 2 * `IOGB_FIXED_TAP + 2, 8, 0};
	int		nbits [3] = '{7, 8, 4};
	logic [1:0]	mode [3] = '{iogb_pkg::IOGB_MODE_7TO1,
		iogb_pkg::IOGB_MODE_8TO1, iogb_pkg::IOGB_MODE_4TO1};
	logic [7:0]	words [7] = '{8'h11, 8'h2e, 8'hc3, 8'h7c, 8'h95, 8'h4a,
		8'hb8};

	iogb_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pad_in, .bypass_comb_input,
		.bypass_clock_output, .rising_sample_out, .falling_or_sdr_sample_out,
		.core_valid, .core_ready, .core_word, .serial_out_a, .serial_out_c);
	iogb_pad_model far (.pclk, .serial_out_a, .serial_out_c, .pad_in,
		.pad_hist, .cap_a, .cap_c);

	always #12.5 pclk = ~pclk;

	task summarize;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			summarize();
		end
	end

	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task check1(input string name, input logic seen, input logic exp);
		check(name, {31'h0, seen}, {31'h0, exp});
	endtask

	// Entered just after a rising edge; the extra edge at the end keeps two
	// calls from driving psel twice in one time step.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task push(input logic [7:0] w);
		int n;
		core_valid <= 1'b1;
		core_word <= w;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (core_ready !== 1'b1)
				was_full = 1'b1;
		end while (core_ready !== 1'b1 && n < 50);
	endtask

	task upto(input int k);
		while (cyc < c0 + k)
			@(posedge pclk);
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h000, 32'h0);
		check("ctrl reset", rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		check("delay reset", rd, 32'h0);
		apb(1'b1, 12'h004, 32'hffffffff);
		apb(1'b0, 12'h004, 32'h0);
		check("delay code", rd, 32'h1f);
		apb(1'b0, 12'h00c, 32'h0);
		check1("unmapped err", err, 1'b1);
		apb(1'b1, 12'h008, 32'h0);
		check1("status ro err", err, 1'b1);
		apb(1'b1, 12'h004, 32'h3);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h000, cfg[i]);
			repeat (40) @(posedge pclk);
			repeat (4) begin
				#1;
				check1("bypass", bypass_comb_input, cfg[i][4] & pad_in);
				check1("bypass clk", bypass_clock_output, cfg[i][4] & pad_in);
				if (cfg[i] != 32'h10) begin
					check1("rise", rising_sample_out, pad_hist[r_idx[i]]);
					check1("second", falling_or_sdr_sample_out, pad_hist[s_idx[i]]);
				end
				@(posedge pclk);
			end
		end
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 12'h000, {29'h0, mode[i], 1'b0});
			push(8'hd6);
			c0 = cyc;
			core_valid <= 1'b0;
			ex = 32'hd6 & ((32'h1 << nbits[i]) - 32'h1);
			upto(3 + nbits[i]);
			#1;
			check("lane a", cap_a >> (32 - nbits[i]), ex);
			check("lane c", cap_c >> 28, i == 2 ? 32'hd : 32'h0);
			@(posedge pclk);
		end
		apb(1'b1, 12'h000, 32'h2);
		for (int j = 0; j < 7; j++) begin
			push(words[j]);
			if (j == 0)
				c0 = cyc;
		end
		core_valid <= 1'b0;
		upto(59);
		#1;
		check("stream", cap_a, 32'hb84a957c);
		check1("buffer full", was_full, 1'b1);
		@(posedge pclk);
		push(8'hff);
		c0 = cyc;
		core_valid <= 1'b0;
		upto(5);
		apb(1'b1, 12'h000, 32'h3);
		apb(1'b0, 12'h008, 32'h0);
		check("status flush", rd & 32'h27, 32'h0);
		check1("serial held", serial_out_a, 1'b0);
		apb(1'b1, 12'h000, 32'h2);
		repeat (8) @(posedge pclk);
		#1;
		check("after reset", cap_a >> 24, 32'h0);
		summarize();
	end
endmodule

// *** hw/iogb_buf2.sv ***
// Small valid/ready buffer of flip-flops between the core and the gearbox.
`timescale 1ns/1ps
module iogb_buf2 #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clr,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data,
	output logic              full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	logic          push;
	logic          pop;

	assign full      = (count == (AW+1)'(DEPTH));
	assign in_ready  = !full;
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clr) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= bump(wr_ptr);
			if (pop)
				rd_ptr <= bump(rd_ptr);
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

	// Storage needs no reset; only the count says what is valid.
	always_ff @(posedge pclk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

// *** hw/iogb_in_cell.sv ***
// Input register block: bypass, delay, single or double rate capture.
`timescale 1ns/1ps
`include "iogb_regs.svh"
module iogb_in_cell #(
	parameter int TAPS        = `IOGB_DLY_TAPS,
	parameter int FIXED_TAP   = `IOGB_FIXED_TAP,
	parameter bit BOTTOM_EDGE = 1'b1
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       pad_in,
	input  wire logic       bypass,
	input  wire logic       fix_dly,
	input  wire logic       dyn_dly,
	input  wire logic       ddr,
	input  wire logic [4:0] dynamic_delay_code,
	output logic            bypass_comb_input,
	output logic            bypass_clock_output,
	output logic            rising_sample_out,
	output logic            falling_or_sdr_sample_out
);
	logic [TAPS-1:0] dly_line;
	logic            dly_out;
	logic            rise_q;
	logic            fall_q;

	// The delay line is modelled in clock steps of the system clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dly_line <= '0;
		else
			dly_line <= {dly_line[TAPS-2:0], pad_in};
	end

	always_comb begin
		if (dyn_dly && BOTTOM_EDGE)
			dly_out = dly_line[dynamic_delay_code]; // [R3]
		else if (fix_dly)
			dly_out = dly_line[FIXED_TAP]; // [R2]
		else
			dly_out = pad_in;
	end

	assign bypass_comb_input   = bypass ? pad_in : 1'b0; // [R1]
	assign bypass_clock_output = bypass ? pad_in : 1'b0; // [R1]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rise_q <= 1'b0;
		else
			rise_q <= dly_out; // [R4]
	end

	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn)
			fall_q <= 1'b0;
		else
			fall_q <= dly_out; // [R5]
	end

	assign rising_sample_out         = rise_q; // [R11]
	assign falling_or_sdr_sample_out = ddr ? fall_q : rise_q; // [R11]
endmodule

// *** hw/iogb_top.sv ***
// I/O cell logic: input register block and output gearbox with APB control.
// Summary of operation
// [R1] Bypass passes pad straight to core and clock.
// [R2] Optional fixed delay before input registers.
// [R3] Bottom edge adds five-bit dynamic delay code.
// [R4] Single rate: one register on system clock.
// [R5] DDR: rising and falling samples, two streams.
// [R6] Gearbox modes: 7:1, 8:1 or dual 4:1.
// [R7] Eight-bit word; bits used depend on mode.
// [R8] Stage one captures word on slow clock; code captures it on pclk, which also shifts out the serial bits.
// [R9] Stage two hands word to fast stage.
// [R10] Stage three shifts word out serially.
// [R11] Rising sample out; second single-rate or falling.
// [R12] Gearbox reset clears pipeline, output low.
// [R13] Bit zero first, ascending order, fixed ratio.
`timescale 1ns/1ps
`include "iogb_regs.svh"
module iogb_top #(
	parameter int FIXED_TAP   = `IOGB_FIXED_TAP,
	parameter bit BOTTOM_EDGE = 1'b1,
	parameter int BUF_DEPTH   = 2
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pad_in,
	output logic             bypass_comb_input,
	output logic             bypass_clock_output,
	output logic             rising_sample_out,
	output logic             falling_or_sdr_sample_out,
	input  wire logic        core_valid,
	output logic             core_ready,
	input  wire logic [7:0]  core_word,
	output logic             serial_out_a,
	output logic             serial_out_c
);
	iogb_pkg::iogb_ctrl_t  ctrl;
	logic [`IOGB_DELAY_W-1:0] dynamic_delay_code;
	iogb_pkg::iogb_mode_t  mode;
	iogb_pkg::iogb_stage_t stage1;
	iogb_pkg::iogb_stage_t stage2;
	iogb_pkg::iogb_ser_t   ser_state;
	logic [7:0]  shift_word;
	logic [2:0]  bit_idx;
	logic [2:0]  next_idx;
	logic        buf_valid;
	logic        buf_full;
	logic [7:0]  buf_word;
	logic        take1;
	logic        take2;
	logic        load3;
	logic        last_bit;
	logic        gb_rst;
	logic        setup;
	logic        wr_en;
	logic        mapped;
	logic [31:0] rd_mux;

	assign mode   = iogb_pkg::iogb_mode_t'(ctrl.mode);
	assign gb_rst = ctrl.gb_rst;

	// Last bit index of a word for each ratio; the ratio fixes how many
	// system clocks one parallel word lasts on the serial line.
	function automatic logic [2:0] last_index(input iogb_pkg::iogb_mode_t m);
		case (m)
			iogb_pkg::IOGB_MODE_7TO1: last_index = 3'h6; // [R13]
			iogb_pkg::IOGB_MODE_8TO1: last_index = 3'h7;
			iogb_pkg::IOGB_MODE_4TO1: last_index = 3'h3;
			default:                  last_index = 3'h7;
		endcase
	endfunction

	// Register bus.
	assign pready = 1'b1;
	assign setup  = psel && !penable;
	assign wr_en  = psel && penable && pwrite;

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0;
		case (paddr)
			`IOGB_CTRL_OFS:
				rd_mux = {{(32-`IOGB_CTRL_W){1'b0}}, ctrl};
			`IOGB_DELAY_OFS:
				rd_mux = {{(32-`IOGB_DELAY_W){1'b0}}, dynamic_delay_code};
			`IOGB_STATUS_OFS: begin
				rd_mux[`IOGB_ST_RUN]      = (ser_state == iogb_pkg::IOGB_SER_RUN);
				rd_mux[`IOGB_ST_S1_FULL]  = stage1.full;
				rd_mux[`IOGB_ST_S2_FULL]  = stage2.full;
				rd_mux[`IOGB_ST_RISE]     = rising_sample_out;
				rd_mux[`IOGB_ST_FALL]     = falling_or_sdr_sample_out;
				rd_mux[`IOGB_ST_BUF_FULL] = buf_full;
			end
			default:
				mapped = 1'b0;
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0 : rd_mux;
			pslverr <= !mapped || (pwrite && paddr == `IOGB_STATUS_OFS);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= `IOGB_CTRL_RESET;
		else if (wr_en && paddr == `IOGB_CTRL_OFS)
			ctrl <= pwdata[`IOGB_CTRL_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dynamic_delay_code <= `IOGB_DELAY_RESET;
		else if (wr_en && paddr == `IOGB_DELAY_OFS)
			dynamic_delay_code <= pwdata[`IOGB_DELAY_W-1:0]; // [R3]
	end

	// Input path.
	iogb_in_cell #(
		.TAPS        (`IOGB_DLY_TAPS),
		.FIXED_TAP   (FIXED_TAP),
		.BOTTOM_EDGE (BOTTOM_EDGE)
	) u_in (
		.pclk                      (pclk),
		.presetn                   (presetn),
		.pad_in                    (pad_in),
		.bypass                    (ctrl.bypass),
		.fix_dly                   (ctrl.fix_dly),
		.dyn_dly                   (ctrl.dyn_dly),
		.ddr                       (ctrl.ddr),
		.dynamic_delay_code        (dynamic_delay_code),
		.bypass_comb_input         (bypass_comb_input),
		.bypass_clock_output       (bypass_clock_output),
		.rising_sample_out         (rising_sample_out),
		.falling_or_sdr_sample_out (falling_or_sdr_sample_out)
	);

	// Output path: the buffer absorbs a stall of the gearbox so that no
	// core word is lost; core_ready falls while it is full.
	iogb_buf2 #(
		.W     (`IOGB_WORD_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.pclk      (pclk),
		.presetn   (presetn),
		.clr       (gb_rst),
		.in_valid  (core_valid),
		.in_ready  (core_ready),
		.in_data   (core_word),
		.out_valid (buf_valid),
		.out_ready (take1),
		.out_data  (buf_word),
		.full      (buf_full)
	);

	assign last_bit = (bit_idx == last_index(mode));
	assign load3    = stage2.full &&
		(ser_state == iogb_pkg::IOGB_SER_IDLE || last_bit);
	assign take2    = stage1.full && (!stage2.full || load3);
	assign take1    = !gb_rst && buf_valid && (!stage1.full || take2);
	assign next_idx = 3'(bit_idx + 3'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stage1 <= '0;
		else if (gb_rst)
			stage1 <= '0; // [R12]
		else if (take1)
			stage1 <= '{full: 1'b1, word: buf_word}; // [R8]
		else if (take2)
			stage1.full <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stage2 <= '0;
		else if (gb_rst)
			stage2 <= '0; // [R12]
		else if (take2)
			stage2 <= stage1; // [R9]
		else if (load3)
			stage2.full <= 1'b0;
	end

	// Stage three: lane A carries bits 0 to 6 in 7:1, the whole word in 8:1 and
	// the low nibble in dual 4:1; lane C carries the high nibble in dual 4:1 and is held low otherwise.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_state    <= iogb_pkg::IOGB_SER_IDLE;
			shift_word   <= 8'h00;
			bit_idx      <= 3'h0;
			serial_out_a <= 1'b0;
			serial_out_c <= 1'b0;
		end else if (gb_rst) begin
			ser_state    <= iogb_pkg::IOGB_SER_IDLE; // [R12]
			shift_word   <= 8'h00;
			bit_idx      <= 3'h0;
			serial_out_a <= 1'b0;
			serial_out_c <= 1'b0;
		end else if (load3) begin
			ser_state    <= iogb_pkg::IOGB_SER_RUN;
			shift_word   <= stage2.word;
			bit_idx      <= 3'h0;
			serial_out_a <= stage2.word[0]; // [R13]
			serial_out_c <= (mode == iogb_pkg::IOGB_MODE_4TO1) ?
				stage2.word[4] : 1'b0; // [R7]
		end else begin
			case (ser_state)
				iogb_pkg::IOGB_SER_RUN: begin
					if (last_bit) begin
						// Starved: drop to low rather than repeat old data.
						ser_state    <= iogb_pkg::IOGB_SER_IDLE;
						serial_out_a <= 1'b0;
						serial_out_c <= 1'b0;
					end else begin
						bit_idx <= next_idx; // [R10]
						if (mode == iogb_pkg::IOGB_MODE_4TO1) begin
							serial_out_a <= shift_word[{1'b0, next_idx[1:0]}]; // [R6]
							serial_out_c <= shift_word[{1'b1, next_idx[1:0]}]; // [R7]
						end else begin
							serial_out_a <= shift_word[next_idx]; // [R13]
							serial_out_c <= 1'b0;
						end
					end
				end
				default: begin
					serial_out_a <= 1'b0;
					serial_out_c <= 1'b0;
				end
			endcase
		end
	end
endmodule

// *** shared/iogb_pkg.sv ***
// Types shared by the I/O gearbox design files.
package iogb_pkg;

	typedef enum logic [1:0] {
		IOGB_MODE_7TO1 = 2'b00,
		IOGB_MODE_8TO1 = 2'b01,
		IOGB_MODE_4TO1 = 2'b10
	} iogb_mode_t;

	typedef enum logic [0:0] {
		IOGB_SER_IDLE = 1'b0,
		IOGB_SER_RUN  = 1'b1
	} iogb_ser_t;

	typedef struct packed {
		logic dyn_dly;
		logic fix_dly;
		logic bypass;
		logic ddr;
		logic [1:0] mode;
		logic gb_rst;
	} iogb_ctrl_t;

	typedef struct packed {
		logic       full;
		logic [7:0] word;
	} iogb_stage_t;

endpackage

// *** shared/iogb_regs.svh ***
// Register offsets, field positions, reset values and counts of the I/O gearbox.
`ifndef IOGB_REGS_SVH
`define IOGB_REGS_SVH

`define IOGB_CTRL_OFS        12'h000
`define IOGB_DELAY_OFS       12'h004
`define IOGB_STATUS_OFS      12'h008

`define IOGB_CTRL_GB_RST     0
`define IOGB_CTRL_MODE_LO    1
`define IOGB_CTRL_MODE_HI    2
`define IOGB_CTRL_DDR        3
`define IOGB_CTRL_BYPASS     4
`define IOGB_CTRL_FIX_DLY    5
`define IOGB_CTRL_DYN_DLY    6
`define IOGB_CTRL_W          7
`define IOGB_CTRL_RESET      7'h00

`define IOGB_DELAY_W         5
`define IOGB_DELAY_RESET     5'h00

`define IOGB_ST_RUN          0
`define IOGB_ST_S1_FULL      1
`define IOGB_ST_S2_FULL      2
`define IOGB_ST_RISE         3
`define IOGB_ST_FALL         4
`define IOGB_ST_BUF_FULL     5

`define IOGB_WORD_W          8
`define IOGB_DLY_TAPS        32
`define IOGB_FIXED_TAP       4

`endif
